//--- hdl/fcr_cfg_regs.sv
// Closed-loop configuration register bank with Avalon-MM slave and field decode
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module fcr_cfg_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Stop control
  output logic      [2:0]  stop_method,
  output logic      [13:0] stop_brake_ms,
  output logic      [9:0]  spindown_threshold,
  output logic      [9:0]  brake_threshold,
  // Motor model
  output logic      [7:0]  winding_resistance,
  output logic      [7:0]  winding_inductance,
  output logic      [7:0]  back_emf_constant,
  // Current loop
  output logic             current_gain_auto,
  output logic      [1:0]  current_prop_scale,
  output logic      [7:0]  current_prop_value,
  output logic      [1:0]  current_integ_scale,
  output logic      [7:0]  current_integ_value,
  // Velocity loop
  output logic      [1:0]  velocity_prop_scale,
  output logic      [7:0]  velocity_prop_value,
  output logic      [1:0]  velocity_integ_scale,
  output logic      [7:0]  velocity_integ_value,
  output logic      [13:0] speed_ceiling_hz
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] stop_brake_motor_param_cfg_r;
  logic [31:0] current_gain_bemf_cfg_r;
  logic [31:0] speed_gain_ceiling_cfg_r;
  logic        ack_r;
  logic [7:0]  widx;
  logic        word_ok;
  logic [31:0] bmask;
  logic        hit_stop;
  logic        hit_cur;
  logic        hit_spd;
  logic        req;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access: answer comes on the edge after the request shows
  assign req      = avs_read | avs_write;
  assign word_ok  = (avs_address[1:0] == 2'h0);
  assign widx     = avs_address[9:2];
  assign hit_stop = word_ok && (widx == fcr_pkg::IDX_STOP_BRAKE);
  assign hit_cur  = word_ok && (widx == fcr_pkg::IDX_CUR_GAIN);
  assign hit_spd  = word_ok && (widx == fcr_pkg::IDX_SPD_GAIN);
  assign avs_waitrequest = req & ~ack_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = avs_byteenable[i] ? 8'hFF : 8'h00;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // Register writes; every bit including 31 is plain read/write
  // ----------------------------------------------------------------
  // A write lands on the edge at which waitrequest is seen low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_brake_motor_param_cfg_r <= fcr_pkg::RESET_VAL;
    end else if (avs_write && ack_r && hit_stop) begin
      // Parity bit stored as is, its rule being unknown
      stop_brake_motor_param_cfg_r <= (stop_brake_motor_param_cfg_r & ~bmask)
                                      | (avs_writedata & bmask);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_gain_bemf_cfg_r <= fcr_pkg::RESET_VAL;
    end else if (avs_write && ack_r && hit_cur) begin
      current_gain_bemf_cfg_r <= (current_gain_bemf_cfg_r & ~bmask)
                                 | (avs_writedata & bmask);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_gain_ceiling_cfg_r <= fcr_pkg::RESET_VAL;
    end else if (avs_write && ack_r && hit_spd) begin
      speed_gain_ceiling_cfg_r <= (speed_gain_ceiling_cfg_r & ~bmask)
                                  | (avs_writedata & bmask);
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered and held until the next read
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= fcr_pkg::UNMAPPED;
    end else if (avs_read && !ack_r) begin
      if (hit_stop) begin
        avs_readdata <= stop_brake_motor_param_cfg_r;
      end else if (hit_cur) begin
        avs_readdata <= current_gain_bemf_cfg_r;
      end else if (hit_spd) begin
        avs_readdata <= speed_gain_ceiling_cfg_r;
      end else begin
        avs_readdata <= fcr_pkg::UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode, combinational
  // ----------------------------------------------------------------
  logic [2:0]  stop_code;
  logic [2:0]  stop_nxt;
  logic [3:0]  brk_code;
  logic [9:0]  cur_kp;
  logic [9:0]  cur_ki;
  logic [9:0]  vel_kp;
  logic [9:0]  vel_ki;
  logic [13:0] ceil_code;
  logic [13:0] ceil_nxt;

  assign stop_code = stop_brake_motor_param_cfg_r[fcr_pkg::STOP_HI:fcr_pkg::STOP_LO];
  assign brk_code  = stop_brake_motor_param_cfg_r[fcr_pkg::BRKT_HI:fcr_pkg::BRKT_LO];

  always_comb begin
    unique case (stop_code)
      3'h0:    stop_nxt = 3'(fcr_pkg::FCR_STOP_HIZ);
      3'h1:    stop_nxt = 3'(fcr_pkg::FCR_STOP_RECIRC);
      3'h2:    stop_nxt = 3'(fcr_pkg::FCR_STOP_LSBRAKE);
      fcr_pkg::STOP_LSB_ALT:
               stop_nxt = 3'(fcr_pkg::FCR_STOP_LSBRAKE);
      3'h4:    stop_nxt = 3'(fcr_pkg::FCR_STOP_SPINDN);
      // Undefined codes fall back to hi-z so drivers never float oddly
      default: stop_nxt = 3'(fcr_pkg::FCR_STOP_HIZ);
    endcase
  end

  assign cur_kp = current_gain_bemf_cfg_r[fcr_pkg::CKP_HI:fcr_pkg::CKP_LO];
  assign cur_ki = current_gain_bemf_cfg_r[fcr_pkg::CKI_HI:fcr_pkg::CKI_LO];
  // Upper three bits from the second register, lower seven from the third
  assign vel_kp = {current_gain_bemf_cfg_r[fcr_pkg::VKPH_HI:fcr_pkg::VKPH_LO],
                   speed_gain_ceiling_cfg_r[fcr_pkg::VKPL_HI:fcr_pkg::VKPL_LO]};
  assign vel_ki = speed_gain_ceiling_cfg_r[fcr_pkg::VKI_HI:fcr_pkg::VKI_LO];
  assign ceil_code = speed_gain_ceiling_cfg_r[fcr_pkg::CEIL_HI:fcr_pkg::CEIL_LO];

  // Integer hertz; fractional part dropped to keep the datapath small
  always_comb begin
    if (ceil_code <= fcr_pkg::CEIL_KNEE) begin
      ceil_nxt = 14'(ceil_code / 14'(fcr_pkg::CEIL_DIV_LO));
    end else begin
      ceil_nxt = 14'((ceil_code >> fcr_pkg::CEIL_SHIFT_HI) - fcr_pkg::CEIL_OFFSET);
    end
  end

  logic [9:0] spin_pm;
  logic [9:0] brake_pm;

  fcr_pct_lut u_spin_lut (
    .code     (stop_brake_motor_param_cfg_r[fcr_pkg::SPIN_HI:fcr_pkg::SPIN_LO]),
    .permille (spin_pm)
  );

  fcr_pct_lut u_brake_lut (
    .code     (stop_brake_motor_param_cfg_r[fcr_pkg::BRKS_HI:fcr_pkg::BRKS_LO]),
    .permille (brake_pm)
  );

  // ----------------------------------------------------------------
  // Registered outputs toward the control algorithm
  // ----------------------------------------------------------------
  // One block per concern; each output trails its field by one clock

  // ----------------------------------------------------------------
  // Stop control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_method <= 3'h0;
    end else begin
      stop_method <= stop_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_brake_ms <= 14'h0000;
    end else begin
      stop_brake_ms <= fcr_pkg::BRK_MS[brk_code];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spindown_threshold <= 10'h000;
    end else begin
      spindown_threshold <= spin_pm;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brake_threshold <= 10'h000;
    end else begin
      brake_threshold <= brake_pm;
    end
  end

  // ----------------------------------------------------------------
  // Motor model
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      winding_resistance <= 8'h00;
    end else begin
      winding_resistance <=
        stop_brake_motor_param_cfg_r[fcr_pkg::RES_HI:fcr_pkg::RES_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      winding_inductance <= 8'h00;
    end else begin
      winding_inductance <=
        stop_brake_motor_param_cfg_r[fcr_pkg::IND_HI:fcr_pkg::IND_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      back_emf_constant <= 8'h00;
    end else begin
      back_emf_constant <=
        current_gain_bemf_cfg_r[fcr_pkg::BEMF_HI:fcr_pkg::BEMF_LO];
    end
  end

  // ----------------------------------------------------------------
  // Current loop
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_gain_auto <= 1'b1;
    end else begin
      // Either field at zero hands both gains to the automatic calculation
      current_gain_auto <= (cur_kp == fcr_pkg::GAIN_AUTO)
                           || (cur_ki == fcr_pkg::GAIN_AUTO);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_prop_scale <= 2'h0;
    end else begin
      current_prop_scale <= cur_kp[fcr_pkg::GSCL_HI:fcr_pkg::GSCL_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_prop_value <= 8'h00;
    end else begin
      current_prop_value <= cur_kp[fcr_pkg::GVAL_HI:fcr_pkg::GVAL_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_integ_scale <= 2'h0;
    end else begin
      current_integ_scale <= cur_ki[fcr_pkg::GSCL_HI:fcr_pkg::GSCL_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      current_integ_value <= 8'h00;
    end else begin
      current_integ_value <= cur_ki[fcr_pkg::GVAL_HI:fcr_pkg::GVAL_LO];
    end
  end

  // ----------------------------------------------------------------
  // Velocity loop
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      velocity_prop_scale <= 2'h0;
      velocity_prop_value <= 8'h00;
    end else begin
      velocity_prop_scale <= vel_kp[fcr_pkg::GSCL_HI:fcr_pkg::GSCL_LO];
      velocity_prop_value <= vel_kp[fcr_pkg::GVAL_HI:fcr_pkg::GVAL_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      velocity_integ_scale <= 2'h0;
      velocity_integ_value <= 8'h00;
    end else begin
      velocity_integ_scale <= vel_ki[fcr_pkg::GSCL_HI:fcr_pkg::GSCL_LO];
      velocity_integ_value <= vel_ki[fcr_pkg::GVAL_HI:fcr_pkg::GVAL_LO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_ceiling_hz <= 14'h0000;
    end else begin
      speed_ceiling_hz <= ceil_nxt;
    end
  end

endmodule : fcr_cfg_regs

//--- hdl/fcr_pkg.sv
// Package: register map, field layout and decode tables for the closed-loop config bank
package fcr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register indices as printed; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STOP_BRAKE = 8'h8A;
  localparam logic [7:0] IDX_CUR_GAIN   = 8'h8C;
  localparam logic [7:0] IDX_SPD_GAIN   = 8'h8E;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PAR_B      = 31;
  localparam int STOP_HI    = 30;
  localparam int STOP_LO    = 28;
  localparam int BRKT_HI    = 27;
  localparam int BRKT_LO    = 24;
  localparam int SPIN_HI    = 23;
  localparam int SPIN_LO    = 20;
  localparam int BRKS_HI    = 19;
  localparam int BRKS_LO    = 16;
  localparam int RES_HI     = 15;
  localparam int RES_LO     = 8;
  localparam int IND_HI     = 7;
  localparam int IND_LO     = 0;
  localparam int BEMF_HI    = 30;
  localparam int BEMF_LO    = 23;
  localparam int CKP_HI     = 22;
  localparam int CKP_LO     = 13;
  localparam int CKI_HI     = 12;
  localparam int CKI_LO     = 3;
  localparam int VKPH_HI    = 2;
  localparam int VKPH_LO    = 0;
  localparam int VKPL_HI    = 30;
  localparam int VKPL_LO    = 24;
  localparam int VKI_HI     = 23;
  localparam int VKI_LO     = 14;
  localparam int CEIL_HI    = 13;
  localparam int CEIL_LO    = 0;
  // Gain code split
  localparam int GSCL_HI    = 9;
  localparam int GSCL_LO    = 8;
  localparam int GVAL_HI    = 7;
  localparam int GVAL_LO    = 0;

  // ----------------------------------------------------------------
  // Stop methods and decode constants
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCR_STOP_HIZ     = 3'h0,
    FCR_STOP_RECIRC  = 3'h1,
    FCR_STOP_LSBRAKE = 3'h2,
    FCR_STOP_SPINDN  = 3'h4
  } fcr_stop_e;

  localparam logic [2:0]  STOP_LSB_ALT  = 3'h3;
  localparam logic [13:0] CEIL_KNEE     = 14'h2580;  // 9600
  localparam int          CEIL_DIV_LO   = 6;
  localparam int          CEIL_SHIFT_HI = 2;         // divide by four
  localparam logic [13:0] CEIL_OFFSET   = 14'h0320;  // 800
  localparam logic [9:0]  GAIN_AUTO     = 10'h000;

  // Brake duration table in milliseconds, indexed by code
  localparam logic [13:0] BRK_MS [16] = '{
    14'h0001, 14'h0001, 14'h0001, 14'h0001, 14'h0001, 14'h0005, 14'h000A, 14'h0032,
    14'h0064, 14'h00FA, 14'h01F4, 14'h03E8, 14'h09C4, 14'h1388, 14'h2710, 14'h3A98};

  // Threshold table in tenths of a percent of the speed ceiling
  localparam logic [9:0] THR_PMIL [16] = '{
    10'h3E8, 10'h384, 10'h320, 10'h2BC, 10'h258, 10'h1F4, 10'h1C2, 10'h190,
    10'h15E, 10'h12C, 10'h0FA, 10'h0C8, 10'h096, 10'h064, 10'h032, 10'h019};

endpackage : fcr_pkg

//--- hdl/fcr_pct_lut.sv
// Threshold code to per-mille of the speed ceiling
`timescale 1ns/1ps
module fcr_pct_lut (
  // Code in
  input  wire logic [3:0] code,
  // Per-mille out
  output logic      [9:0] permille
);
  assign permille = fcr_pkg::THR_PMIL[code];
endmodule : fcr_pct_lut

//--- tb/fcr_cfg_regs_sva.sv
// Checker: bus handshake and register-to-output relations of the config bank
`timescale 1ns/1ps
module fcr_cfg_regs_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Decoded fields
  input wire logic [2:0]  stop_method,
  input wire logic [7:0]  winding_resistance,
  input wire logic [7:0]  winding_inductance,
  input wire logic [7:0]  back_emf_constant,
  input wire logic        current_gain_auto,
  input wire logic [1:0]  velocity_integ_scale,
  input wire logic [7:0]  velocity_integ_value
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        req;
  logic [31:0] wd1_r;
  logic [31:0] wd2_r;
  assign req = avs_read | avs_write;
  // Write data two edges back, lined up with the one-clock decode lag
  always_ff @(posedge mclk) begin
    wd1_r <= avs_writedata;
    wd2_r <= wd1_r;
  end
  function automatic logic [2:0] stop_map(input logic [2:0] c);
    return (c == 3'h3) ? 3'h2 : ((c > 3'h4) ? 3'h0 : c);
  endfunction : stop_map
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence full_wr(logic [9:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable == 4'hF;
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wait_one_a: assert property ($rose(req) |-> one_wait) else $error("wait not one cycle");
  idle_ready_a: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
  unmap_zero_a: assert property (
    avs_read && !avs_waitrequest && !(avs_address inside {10'h228, 10'h230, 10'h238})
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  stop_dec_a: assert property (
    full_wr(10'h228) |-> ##2 stop_method == stop_map(wd2_r[30:28]))
    else $error("stop method decode wrong");
  res_fld_a: assert property (
    full_wr(10'h228) |-> ##2 winding_resistance == wd2_r[15:8])
    else $error("resistance field wrong");
  ind_fld_a: assert property (
    full_wr(10'h228) |-> ##2 winding_inductance == wd2_r[7:0])
    else $error("inductance field wrong");
  bemf_fld_a: assert property (
    full_wr(10'h230) |-> ##2 back_emf_constant == wd2_r[30:23])
    else $error("back-emf field wrong");
  gain_auto_a: assert property (
    full_wr(10'h230) |-> ##2 current_gain_auto ==
    (wd2_r[22:13] == 10'h000 || wd2_r[12:3] == 10'h000)) else $error("auto gain wrong");
  vinteg_fld_a: assert property (
    full_wr(10'h238) |-> ##2 {velocity_integ_scale, velocity_integ_value} == wd2_r[23:14])
    else $error("velocity integral field wrong");
endmodule : fcr_cfg_regs_chk

bind fcr_cfg_regs fcr_cfg_regs_chk chk_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .stop_method(stop_method),
  .winding_resistance(winding_resistance), .winding_inductance(winding_inductance),
  .back_emf_constant(back_emf_constant), .current_gain_auto(current_gain_auto),
  .velocity_integ_scale(velocity_integ_scale), .velocity_integ_value(velocity_integ_value));

//--- tb/test_fcr_cfg_regs.sv
// Testbench: register access, field decode and reset of the config bank
`timescale 1ns/1ps
module test_fcr_cfg_regs;
  // ----------------------------------------------------------------
  // Signals and expected tables
  // ----------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, q, d;
  logic        avs_waitrequest, current_gain_auto;
  logic [2:0]  stop_method;
  logic [13:0] stop_brake_ms, speed_ceiling_hz;
  logic [9:0]  spindown_threshold, brake_threshold;
  logic [7:0]  winding_resistance, winding_inductance, back_emf_constant;
  logic [1:0]  current_prop_scale, current_integ_scale, velocity_prop_scale, velocity_integ_scale;
  logic [7:0]  current_prop_value, current_integ_value, velocity_prop_value, velocity_integ_value;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          brk_ms [16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000, 10000,
                               15000};
  int          pmil [16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150,
                             100, 50, 25};
  int          ceil_c [6] = '{0, 1500, 9600, 9601, 10000, 16383};
  int          ceil_hz [6] = '{0, 250, 1600, 1600, 1700, 3295};
  logic [9:0]  kp_t [3] = '{10'h000, 10'h2C3, 10'h3FF};
  logic [9:0]  ki_t [3] = '{10'h1A5, 10'h000, 10'h155};

  always #50 mclk = ~mclk;

  fcr_cfg_regs dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_method(stop_method),
    .stop_brake_ms(stop_brake_ms), .spindown_threshold(spindown_threshold),
    .brake_threshold(brake_threshold), .winding_resistance(winding_resistance),
    .winding_inductance(winding_inductance), .back_emf_constant(back_emf_constant),
    .current_gain_auto(current_gain_auto), .current_prop_scale(current_prop_scale),
    .current_prop_value(current_prop_value), .current_integ_scale(current_integ_scale),
    .current_integ_value(current_integ_value), .velocity_prop_scale(velocity_prop_scale),
    .velocity_prop_value(velocity_prop_value), .velocity_integ_scale(velocity_integ_scale),
    .velocity_integ_value(velocity_integ_value), .speed_ceiling_hz(speed_ceiling_hz));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low; a gap edge follows the release
  task automatic xfer(input logic is_wr, input logic [9:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= ~is_wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) chk("waitrequest", 32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : xfer

  // Extra edge so the decoded outputs, one clock behind, have landed
  task automatic wr(input logic [9:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, 4'hF);
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
    chk("readdata", q, exp);
  endtask : rd

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #500000;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("auto at reset", current_gain_auto, 32'h1);
    for (int r = 0; r < 3; r++) rd(10'h228 + 10'(8 * r), 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      d = {1'b1, 3'(i), 4'(i), 4'(i), 4'(15 - i), 4'(i), 4'(15 - i), 4'(15 - i), 4'(i)};
      wr(10'h228, d);
      rd(10'h228, d);
      chk("stop", stop_method, (i % 8 == 3) ? 2 : ((i % 8 > 4) ? 0 : i % 8));
      chk("brake ms", stop_brake_ms, brk_ms[i]);
      chk("spindown", spindown_threshold, pmil[i]);
      chk("brake thr", brake_threshold, pmil[15 - i]);
      chk("resistance", winding_resistance, d[15:8]);
      chk("inductance", winding_inductance, d[7:0]);
    end
    $display("test stop fields done");
    for (int i = 0; i < 3; i++) begin
      wr(10'h230, {1'b0, 8'hC3 ^ 8'(i), kp_t[i], ki_t[i], 3'h5});
      chk("bemf", back_emf_constant, 8'hC3 ^ 8'(i));
      chk("cur kp", {current_prop_scale, current_prop_value}, kp_t[i]);
      chk("cur ki", {current_integ_scale, current_integ_value}, ki_t[i]);
      chk("auto", current_gain_auto, (kp_t[i] == 0 || ki_t[i] == 0));
    end
    $display("test current gains done");
    for (int i = 0; i < 6; i++) begin
      wr(10'h238, {1'b1, 7'h5A, 10'h2E7, 14'(ceil_c[i])});
      chk("vel kp", {velocity_prop_scale, velocity_prop_value}, 10'h2DA);
      chk("vel ki", {velocity_integ_scale, velocity_integ_value}, 10'h2E7);
      chk("ceiling", speed_ceiling_hz, ceil_hz[i]);
    end
    $display("test velocity fields done");
    xfer(1'b1, 10'h228, 32'hFFFF_FFFF, 4'h2);
    rd(10'h228, {d[31:16], 8'hFF, d[7:0]});
    xfer(1'b1, 10'h22C, 32'hFFFF_FFFF, 4'hF);
    rd(10'h22C, 32'h0000_0000);
    // Misaligned write must leave the first register untouched
    xfer(1'b1, 10'h229, 32'hFFFF_FFFF, 4'hF);
    rd(10'h240, 32'h0000_0000);
    rd(10'h228, {d[31:16], 8'hFF, d[7:0]});
    $display("test lanes and unmapped done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int r = 0; r < 3; r++) rd(10'h228 + 10'(8 * r), 32'h0000_0000);
    chk("stop after reset", stop_method, 32'h0);
    $display("test second reset done");
    test_done();
  end
endmodule : test_fcr_cfg_regs
